// *** logic/tbib_params.svh ***
// constants for the thermal and button interrupt bank
`ifndef TBIB_PARAMS_SVH
`define TBIB_PARAMS_SVH

// register offsets (byte wide registers)
`define TBIB_ADDR_THERM_LATCH 8'h20
`define TBIB_ADDR_THERM_GATE 8'h21
`define TBIB_ADDR_THERM_LEVEL 8'h22
`define TBIB_ADDR_BTN_LATCH 8'h24
`define TBIB_ADDR_BTN_GATE 8'h25
`define TBIB_ADDR_BTN_LEVEL 8'h26
`define TBIB_ADDR_DEB_CFG 8'h30
`define TBIB_ADDR_PIN_LEVEL 8'h31

// field positions
`define TBIB_BIT_LOWER_HEAT 0
`define TBIB_BIT_UPPER_HEAT 2
`define TBIB_BIT_PUSH 0
`define TBIB_BIT_HOLD_LO 1
`define TBIB_BIT_HOLD_HI 5
`define TBIB_DEB_FALL_LO 0
`define TBIB_DEB_RISE_LO 4

// implemented bits and reset values
`define TBIB_THERM_USED 8'h05
`define TBIB_BTN_USED 8'h3F
`define TBIB_LATCH_RESET 8'h00
`define TBIB_THERM_GATE_RESET 8'h05
`define TBIB_BTN_GATE_RESET 8'h3F
`define TBIB_DEB_CFG_RESET 8'h22

// timing
`define TBIB_CLK_PERIOD_NS 5
`define TBIB_TICK_PERIOD_NS 1000000
`define TBIB_TICK_CYCLES (`TBIB_TICK_PERIOD_NS / `TBIB_CLK_PERIOD_NS)
`define TBIB_TICK_MS 1
`define TBIB_HOLD1_MS 1000
`define TBIB_HOLD2_MS 2000
`define TBIB_HOLD3_MS 3000
`define TBIB_HOLD4_MS 4000
`define TBIB_HOLD8_MS 8000
`define TBIB_HOLD_CNT_W 14

`endif

// *** logic/tbib_pkg.sv ***
// types shared by the thermal and button interrupt bank
package tbib_pkg;
  typedef logic [7:0] tbib_byte_t;
  typedef logic [7:0] tbib_addr_t;
  typedef enum logic {
    DEB_RELEASED,
    DEB_PRESSED
  } tbib_deb_state_t;
endpackage : tbib_pkg

// *** logic/tbib_debounce.sv ***
// power button debouncer with separate press and release dwell
`timescale 1ns/10ps
`default_nettype none
module tbib_debounce (
  input wire logic i_clk, // system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_tick, // millisecond enable pulse
  input wire logic i_pressed, // raw button, 1 = held low
  input wire logic [3:0] i_fall_ticks, // press dwell in ticks
  input wire logic [3:0] i_rise_ticks, // release dwell in ticks
  output logic o_level, // debounced push level
  output logic o_change // one-cycle pulse on level change
);
  import tbib_pkg::*;

  tbib_deb_state_t state_r;
  tbib_deb_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic change_r;
  wire logic differ;
  wire logic [3:0] dwell;
  wire logic flip;

  // a release only counts after a completed press
  assign differ = (state_r == DEB_RELEASED) ? i_pressed : !i_pressed;
  assign dwell = (state_r == DEB_RELEASED) ? i_fall_ticks : i_rise_ticks;
  assign flip = differ && i_tick && (cnt_r >= dwell);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (!differ) begin
      cnt_nxt = 4'h0;
    end else if (flip) begin
      cnt_nxt = 4'h0;
    end else if (i_tick) begin
      cnt_nxt = cnt_r + 4'h1;
    end
    case (state_r)
      DEB_RELEASED: if (flip) state_nxt = DEB_PRESSED;
      DEB_PRESSED: if (flip) state_nxt = DEB_RELEASED;
      default: state_nxt = DEB_RELEASED;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= DEB_RELEASED;
      cnt_r <= 4'h0;
      change_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      change_r <= flip;
    end
  end

  assign o_level = (state_r == DEB_PRESSED);
  assign o_change = change_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_change_marks_flip: assert property ($changed(o_level) |-> o_change)
    else $error("debounced level changed without change pulse");
  a_level_needs_raw: assert property ($rose(o_level) |-> $past(i_pressed) && $past(i_tick))
    else $error("debounced level rose without a held press");
endmodule : tbib_debounce
`default_nettype wire

// *** logic/tbib_hold_timer.sv ***
// hold duration timer for the debounced power button
`timescale 1ns/10ps
`default_nettype none
`include "tbib_params.svh"
module tbib_hold_timer #(
  parameter int CNT_W = `TBIB_HOLD_CNT_W // width of the millisecond counter
) (
  input wire logic i_clk, // system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_tick, // millisecond enable pulse
  input wire logic i_pressed, // debounced push level
  output logic [4:0] o_level, // held beyond 1,2,3,4,8 s
  output logic [4:0] o_event // one-cycle pulse per threshold reached
);
  import tbib_pkg::*;

  function automatic logic [CNT_W-1:0] hold_limit(input int idx);
    case (idx)
      0: hold_limit = CNT_W'(`TBIB_HOLD1_MS / `TBIB_TICK_MS);
      1: hold_limit = CNT_W'(`TBIB_HOLD2_MS / `TBIB_TICK_MS);
      2: hold_limit = CNT_W'(`TBIB_HOLD3_MS / `TBIB_TICK_MS);
      3: hold_limit = CNT_W'(`TBIB_HOLD4_MS / `TBIB_TICK_MS);
      default: hold_limit = CNT_W'(`TBIB_HOLD8_MS / `TBIB_TICK_MS);
    endcase
  endfunction : hold_limit

  logic [CNT_W-1:0] cnt_r;
  wire logic [CNT_W-1:0] cnt_nxt;
  logic [4:0] level_r;
  logic [4:0] event_r;
  wire logic [4:0] level_nxt;

  // counter saturates at the longest threshold so it never wraps
  assign cnt_nxt = !i_pressed ? '0 :
                   (i_tick && cnt_r != hold_limit(4)) ? cnt_r + CNT_W'(1) : cnt_r;

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_hold
      assign level_nxt[g] = i_pressed && (cnt_nxt >= hold_limit(g));
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= '0;
      level_r <= 5'h00;
      event_r <= 5'h00;
    end else begin
      cnt_r <= cnt_nxt;
      level_r <= level_nxt;
      event_r <= level_nxt & ~level_r;
    end
  end

  assign o_level = level_r;
  assign o_event = event_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_hold_clear_release: assert property (!i_pressed |=> o_level == 5'h00)
    else $error("hold levels not cleared on release");
  a_hold_event_edge: assert property (o_event[0] |-> o_level[0] && !$past(o_level[0]))
    else $error("one second event without a fresh hold level");
  a_hold_order: assert property (o_level[4] |-> o_level[3:0] == 4'hF)
    else $error("eight second hold seen before shorter holds");
endmodule : tbib_hold_timer
`default_nettype wire

// *** logic/tbib_top.sv ***
// thermal and power button interrupt bank: latches, gates, levels, irq pin
`timescale 1ns/10ps
`default_nettype none
`include "tbib_params.svh"
module tbib_top #(
  parameter int TICK_CYCLES = `TBIB_TICK_CYCLES // clocks per millisecond tick
) (
  input wire logic I_CLK, // 200 MHz system clock
  input wire logic I_RSTN, // async reset, active low
  input wire tbib_pkg::tbib_addr_t I_ADDR, // register address
  input wire tbib_pkg::tbib_byte_t I_WDATA, // write data
  input wire logic I_WR, // write strobe
  input wire logic I_RD, // read strobe
  output tbib_pkg::tbib_byte_t O_RDATA, // read data, cycle after I_RD
  input wire logic I_TEMP_OVER_LOW, // die above 110 degrees
  input wire logic I_TEMP_OVER_HIGH, // die above 125 degrees
  input wire logic I_POWER_BUTTON_N, // power button, low = pressed
  input wire logic I_IRQ_REQUEST_N_I, // sensed level of request pin
  output logic O_IRQ_REQUEST_N_O, // request pin drive value
  output logic O_IRQ_REQUEST_N_OE // request pin drive enable
);
  import tbib_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  //////////////////////////////////////////////////////////////////////////////
  // millisecond enable

  logic [TICK_W-1:0] tick_cnt_r;
  logic tick_r;
  wire logic tick_wrap;

  assign tick_wrap = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + TICK_W'(1);
      tick_r <= tick_wrap;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register decode

  wire logic hit_therm_latch;
  wire logic hit_therm_gate;
  wire logic hit_therm_level;
  wire logic hit_btn_latch;
  wire logic hit_btn_gate;
  wire logic hit_btn_level;
  wire logic hit_deb_cfg;
  wire logic hit_pin_level;

  assign hit_therm_latch = (I_ADDR == `TBIB_ADDR_THERM_LATCH);
  assign hit_therm_gate = (I_ADDR == `TBIB_ADDR_THERM_GATE);
  assign hit_therm_level = (I_ADDR == `TBIB_ADDR_THERM_LEVEL);
  assign hit_btn_latch = (I_ADDR == `TBIB_ADDR_BTN_LATCH);
  assign hit_btn_gate = (I_ADDR == `TBIB_ADDR_BTN_GATE);
  assign hit_btn_level = (I_ADDR == `TBIB_ADDR_BTN_LEVEL);
  assign hit_deb_cfg = (I_ADDR == `TBIB_ADDR_DEB_CFG);
  assign hit_pin_level = (I_ADDR == `TBIB_ADDR_PIN_LEVEL);

  //////////////////////////////////////////////////////////////////////////////
  // thermal levels and events

  logic [1:0] heat_level_r;
  wire logic [1:0] heat_now;
  wire logic [1:0] heat_cross;
  wire tbib_byte_t heat_level_byte;

  // comparator outputs arrive synchronous; the level register is the only history kept
  assign heat_now = {I_TEMP_OVER_HIGH, I_TEMP_OVER_LOW};
  assign heat_cross = heat_now ^ heat_level_r;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      heat_level_r <= 2'b00;
    end else begin
      heat_level_r <= heat_now;
    end
  end

  assign heat_level_byte = {5'h00, heat_level_r[1], 1'b0, heat_level_r[0]};

  //////////////////////////////////////////////////////////////////////////////
  // button debounce and hold timing

  tbib_byte_t deb_cfg_r;
  wire logic push_level;
  wire logic push_change;
  wire logic [4:0] hold_level;
  wire logic [4:0] hold_event;
  wire tbib_byte_t btn_level_byte;

  tbib_debounce u_debounce (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_tick(tick_r),
    .i_pressed(!I_POWER_BUTTON_N),
    .i_fall_ticks(deb_cfg_r[`TBIB_DEB_FALL_LO +: 4]),
    .i_rise_ticks(deb_cfg_r[`TBIB_DEB_RISE_LO +: 4]),
    .o_level(push_level),
    .o_change(push_change)
  );

  tbib_hold_timer u_hold_timer (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_tick(tick_r),
    .i_pressed(push_level),
    .o_level(hold_level),
    .o_event(hold_event)
  );

  assign btn_level_byte = {2'b00, hold_level, push_level};

  //////////////////////////////////////////////////////////////////////////////
  // event latches, gates and config

  tbib_byte_t therm_latch_r;
  tbib_byte_t therm_gate_r;
  tbib_byte_t btn_latch_r;
  tbib_byte_t btn_gate_r;
  wire tbib_byte_t therm_set;
  wire tbib_byte_t btn_set;
  wire tbib_byte_t therm_clr;
  wire tbib_byte_t btn_clr;
  wire tbib_byte_t therm_latch_nxt;
  wire tbib_byte_t btn_latch_nxt;

  assign therm_set = {5'h00, heat_cross[1], 1'b0, heat_cross[0]};
  assign btn_set = {2'b00, hold_event, push_change};

  // a read clears the whole register; a write clears where it holds ones
  assign therm_clr = (I_RD && hit_therm_latch) ? `TBIB_THERM_USED :
                     (I_WR && hit_therm_latch) ? (I_WDATA & `TBIB_THERM_USED) : 8'h00;
  assign btn_clr = (I_RD && hit_btn_latch) ? `TBIB_BTN_USED :
                   (I_WR && hit_btn_latch) ? (I_WDATA & `TBIB_BTN_USED) : 8'h00;

  // set wins over clear so no event is lost in the clearing cycle
  assign therm_latch_nxt = (therm_latch_r & ~therm_clr) | therm_set;
  assign btn_latch_nxt = (btn_latch_r & ~btn_clr) | btn_set;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      therm_latch_r <= `TBIB_LATCH_RESET;
      btn_latch_r <= `TBIB_LATCH_RESET;
    end else begin
      therm_latch_r <= therm_latch_nxt;
      btn_latch_r <= btn_latch_nxt;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      therm_gate_r <= `TBIB_THERM_GATE_RESET;
      btn_gate_r <= `TBIB_BTN_GATE_RESET;
      deb_cfg_r <= `TBIB_DEB_CFG_RESET;
    end else if (I_WR) begin
      if (hit_therm_gate) therm_gate_r <= I_WDATA & `TBIB_THERM_USED;
      if (hit_btn_gate) btn_gate_r <= I_WDATA & `TBIB_BTN_USED;
      if (hit_deb_cfg) deb_cfg_r <= I_WDATA;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path

  tbib_byte_t rd_mux;
  tbib_byte_t rdata_r;

  always_comb begin
    if (hit_therm_latch) begin
      rd_mux = therm_latch_r;
    end else if (hit_therm_gate) begin
      rd_mux = therm_gate_r;
    end else if (hit_therm_level) begin
      rd_mux = heat_level_byte;
    end else if (hit_btn_latch) begin
      rd_mux = btn_latch_r;
    end else if (hit_btn_gate) begin
      rd_mux = btn_gate_r;
    end else if (hit_btn_level) begin
      rd_mux = btn_level_byte;
    end else if (hit_deb_cfg) begin
      rd_mux = deb_cfg_r;
    end else if (hit_pin_level) begin
      rd_mux = {7'h00, I_IRQ_REQUEST_N_I};
    end else begin
      rd_mux = 8'h00;
    end
  end

  // data stand for one cycle only, zero otherwise
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= I_RD ? rd_mux : 8'h00;
    end
  end

  assign O_RDATA = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // interrupt request pin

  wire tbib_byte_t therm_live;
  wire tbib_byte_t btn_live;
  wire logic irq_pending;

  assign therm_live = therm_latch_r & ~therm_gate_r;
  assign btn_live = btn_latch_r & ~btn_gate_r;
  assign irq_pending = (|therm_live) || (|btn_live);

  // open drain: only ever drives low, released pin floats high outside
  assign O_IRQ_REQUEST_N_O = 1'b0;
  assign O_IRQ_REQUEST_N_OE = irq_pending;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  a_lower_heat_latch: assert property ($changed(heat_level_r[0]) |-> therm_latch_r[0])
    else $error("lower heat crossing not latched");
  a_upper_heat_latch: assert property ($changed(heat_level_r[1]) |-> therm_latch_r[2])
    else $error("upper heat crossing not latched");
  a_latch_holds: assert property (therm_latch_r[0] && !(I_RD && hit_therm_latch)
      && !(I_WR && hit_therm_latch) |=> therm_latch_r[0])
    else $error("lower heat event dropped without a clear");
  a_read_clears_latch: assert property (I_RD && hit_btn_latch && btn_set == 8'h00
      |=> btn_latch_r == 8'h00)
    else $error("button events not cleared by read");
  a_write_one_clears: assert property (I_WR && hit_therm_latch && I_WDATA[2] && !heat_cross[1]
      |=> !therm_latch_r[2])
    else $error("upper heat event not cleared by write of one");
  a_unmasked_pulls_low: assert property (therm_latch_r[0] && !therm_gate_r[0]
      |-> O_IRQ_REQUEST_N_OE && !O_IRQ_REQUEST_N_O)
    else $error("ungated event did not pull request pin low");
  a_gate_blocks_pin: assert property (therm_live == 8'h00 && btn_live == 8'h00
      |-> !O_IRQ_REQUEST_N_OE)
    else $error("request pin driven with all events gated or clear");
  a_gate_reset_set: assert property ($rose(I_RSTN) |-> therm_gate_r == 8'h05
      && btn_gate_r == 8'h3F)
    else $error("gates not set after reset");
  a_level_read_value: assert property (I_RD && hit_therm_level
      |=> O_RDATA == {5'h00, $past(heat_level_r[1]), 1'b0, $past(heat_level_r[0])})
    else $error("heat level read returned wrong value");
  a_push_change_latch: assert property (push_change |=> btn_latch_r[0])
    else $error("push change not latched");
  a_hold_latch: assert property (hold_event[4] |=> btn_latch_r[5])
    else $error("eight second hold not latched");
  a_pin_released: assert property ($fell(irq_pending) |-> therm_live == 8'h00
      && btn_live == 8'h00)
    else $error("request pin released with ungated event set");
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data present without a read");
endmodule : tbib_top
`default_nettype wire

// *** sim/tbib_host_model.sv ***
// host side of the request pin: open drain wire with a pull-up
`timescale 1ns/10ps
`default_nettype none
module tbib_host_model (
  input wire logic i_drive_val, // value the bank drives
  input wire logic i_drive_en, // bank pulls the pin
  output logic o_pin_n // resolved pin level
);
  // released pin floats up to the pull-up, never to the last driven value
  assign o_pin_n = i_drive_en ? i_drive_val : 1'b1;
endmodule : tbib_host_model
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the thermal and button interrupt bank
`timescale 1ns/10ps
`default_nettype none
`include "tbib_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
  import tbib_pkg::*;
  localparam int TICKS = 4;
  logic I_CLK;
  logic I_RSTN;
  tbib_addr_t I_ADDR;
  tbib_byte_t I_WDATA;
  logic I_WR;
  logic I_RD;
  tbib_byte_t O_RDATA;
  logic I_TEMP_OVER_LOW;
  logic I_TEMP_OVER_HIGH;
  logic I_POWER_BUTTON_N;
  logic irq_pin_n;
  logic irq_o;
  logic irq_oe;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  tbib_top #(.TICK_CYCLES(TICKS)) u_dut (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_TEMP_OVER_LOW(I_TEMP_OVER_LOW), .I_TEMP_OVER_HIGH(I_TEMP_OVER_HIGH),
    .I_POWER_BUTTON_N(I_POWER_BUTTON_N), .I_IRQ_REQUEST_N_I(irq_pin_n),
    .O_IRQ_REQUEST_N_O(irq_o), .O_IRQ_REQUEST_N_OE(irq_oe)
  );
  tbib_host_model u_host (.i_drive_val(irq_o), .i_drive_en(irq_oe), .o_pin_n(irq_pin_n));

  initial begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // hang guard: the long hold test needs about 34000 cycles
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      $display("Error %0t: run timed out", $time);
      results();
    end
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge I_CLK);
  endtask : wait_cyc

  // one-cycle write; returns once the write edge has landed
  task automatic wr(input tbib_addr_t a, input tbib_byte_t d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
    #1;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input tbib_addr_t a, output tbib_byte_t d);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    d = O_RDATA;
  endtask : rd

  task automatic rd_chk(input tbib_addr_t a, input tbib_byte_t e);
    tbib_byte_t d;
    rd(a, d);
    `CHK(d, e)
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(`TBIB_ADDR_THERM_LATCH, 8'h00);
    rd_chk(`TBIB_ADDR_THERM_GATE, 8'h05);
    rd_chk(`TBIB_ADDR_THERM_LEVEL, 8'h00);
    rd_chk(`TBIB_ADDR_BTN_LATCH, 8'h00);
    rd_chk(`TBIB_ADDR_BTN_GATE, 8'h3F);
    rd_chk(`TBIB_ADDR_DEB_CFG, 8'h22);
    rd_chk(8'h40, 8'h00);
    `CHK(irq_pin_n, 1'b1)
    $display("test reset values done");
  endtask : t_reset

  task automatic t_thermal;
    @(posedge I_CLK);
    I_TEMP_OVER_LOW <= 1'b1;
    wait_cyc(2);
    rd_chk(`TBIB_ADDR_THERM_LEVEL, 8'h01);
    `CHK(irq_pin_n, 1'b1)
    rd_chk(`TBIB_ADDR_THERM_LATCH, 8'h01);
    rd_chk(`TBIB_ADDR_THERM_LATCH, 8'h00);
    wr(`TBIB_ADDR_THERM_GATE, 8'h00);
    @(posedge I_CLK);
    I_TEMP_OVER_HIGH <= 1'b1;
    wait_cyc(2);
    #1;
    `CHK(irq_pin_n, 1'b0)
    rd_chk(`TBIB_ADDR_PIN_LEVEL, 8'h00);
    wr(`TBIB_ADDR_THERM_LATCH, 8'h04);
    `CHK(irq_pin_n, 1'b1)
    rd_chk(`TBIB_ADDR_THERM_LEVEL, 8'h05);
    @(posedge I_CLK);
    I_TEMP_OVER_HIGH <= 1'b0;
    wait_cyc(2);
    #1;
    `CHK(irq_pin_n, 1'b0)
    @(posedge I_CLK);
    I_TEMP_OVER_LOW <= 1'b0;
    wait_cyc(2);
    wr(`TBIB_ADDR_THERM_LATCH, 8'h01);
    `CHK(irq_pin_n, 1'b0)
    wr(`TBIB_ADDR_THERM_GATE, 8'h05);
    `CHK(irq_pin_n, 1'b1)
    rd_chk(`TBIB_ADDR_THERM_LATCH, 8'h04);
    rd_chk(`TBIB_ADDR_THERM_LEVEL, 8'h00);
    $display("test thermal done");
  endtask : t_thermal

  task automatic t_button;
    // short press must not pass the press dwell of 2 ticks
    @(posedge I_CLK);
    I_POWER_BUTTON_N <= 1'b0;
    wait_cyc(4);
    I_POWER_BUTTON_N <= 1'b1;
    wait_cyc(40);
    rd_chk(`TBIB_ADDR_BTN_LEVEL, 8'h00);
    rd_chk(`TBIB_ADDR_BTN_LATCH, 8'h00);
    @(posedge I_CLK);
    I_POWER_BUTTON_N <= 1'b0;
    wait_cyc(40);
    rd_chk(`TBIB_ADDR_BTN_LEVEL, 8'h01);
    rd_chk(`TBIB_ADDR_BTN_LATCH, 8'h01);
    wait_cyc(4050);
    rd_chk(`TBIB_ADDR_BTN_LEVEL, 8'h03);
    wait_cyc(29000);
    rd_chk(`TBIB_ADDR_BTN_LEVEL, 8'h3F);
    wr(`TBIB_ADDR_BTN_GATE, 8'h00);
    `CHK(irq_pin_n, 1'b0)
    rd_chk(`TBIB_ADDR_BTN_LATCH, 8'h3E);
    `CHK(irq_pin_n, 1'b1)
    @(posedge I_CLK);
    I_POWER_BUTTON_N <= 1'b1;
    wait_cyc(40);
    #1;
    `CHK(irq_pin_n, 1'b0)
    rd_chk(`TBIB_ADDR_BTN_LEVEL, 8'h00);
    rd_chk(`TBIB_ADDR_BTN_LATCH, 8'h01);
    wr(`TBIB_ADDR_BTN_GATE, 8'h3F);
    $display("test button done");
  endtask : t_button

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    I_RSTN = 1'b0;
    I_ADDR = 8'h00;
    I_WDATA = 8'h00;
    I_WR = 1'b0;
    I_RD = 1'b0;
    I_TEMP_OVER_LOW = 1'b0;
    I_TEMP_OVER_HIGH = 1'b0;
    I_POWER_BUTTON_N = 1'b1;
    wait_cyc(2);
    I_RSTN <= 1'b1;
    t_reset();
    t_thermal();
    t_button();
    results();
  end
endmodule : tb
`default_nettype wire
